// >>> urx9_receiver.v
/*
 * Nine-bit serial receiver top: start detection, majority sampling,
 * frame load, register port and timer 2 flags.
 * Assumes clk is the oscillator clock and rx_pin is asynchronous.
 */
// The implementer's own choices: the address-and-strobe port and the register offsets.
// Function
// - Start reception on falling edge of receive pin, sampled at sixteen ticks per bit.
// - On start edge load all ones into shifter and reset bit counter.
// - Sample in counter states seven, eight, nine; accept two-of-three majority.
// - Non-low first bit resets receiver back to edge hunting.
// - Bits enter right, ones leave left; start at left triggers final shift.
// - Load only when done flag clear and filter off or ninth bit one.
// - Load ninth bit flag, eight data bits to buffer, set done flag.
// - One bit time after final shift, return to edge hunting.
// - Stop bit value never affects buffer, ninth bit or done flag.
// - Fixed mode with doubling clear runs at oscillator over thirty-two.
// - Timer 1 baud equals overflow rate times two-power doubling over 32.
// - Timer 2 overflow reloads the count from the reload pair.
// - Timer 2 counts at oscillator over two in baud mode.
// - Timer 2 baud equals oscillator over 32 times (65536 minus reload).
// - Timer 2 rollover sets no overflow flag and raises no interrupt.
// - External pin falling edge sets external flag without reload when enabled.
// - Frame is low start, eight data LSB first, ninth bit, high stop.
// - Fixed mode selects oscillator over thirty-two or over sixty-four.
`timescale 1ns/1ps
`include "urx9_defines.vh"

module urx9_receiver (
    // Clock and reset
    input  wire       clk,
    input  wire       sys_rst,
    // Register port
    input  wire [3:0] reg_addr,
    input  wire [7:0] reg_wdata,
    input  wire       reg_wr,
    input  wire       reg_rd,
    output reg  [7:0] reg_rdata,
    // Serial and timer pins
    input  wire       rx_pin,
    input  wire       timer2_external_pin,
    // Status outputs
    output reg        rx_done_flag,
    output reg        rx_ninth_bit,
    output reg  [7:0] serial_buffer,
    output reg        timer2_external_flag
);

    // ****************************************************************
    // State and storage
    // ****************************************************************
    // The control byte holds, from bit 0 up: receive enable, multiprocessor
    // filter, doubling select, timer mode, timer 2 select, timer 2 run,
    // external flag enable and timer 1 run. Status holds, from bit 0 up:
    // done, ninth bit, timer 2 overflow, external flag and busy.
    // Idle hunts for a start edge, frame collects ten bit times, and tail
    // waits out the stop bit.
    localparam ST_IDLE  = 2'd0;
    localparam ST_FRAME = 2'd1;
    localparam ST_TAIL  = 2'd2;

    reg [7:0]  ctrl_q;
    reg [7:0]  t1_reload_q;
    reg [15:0] t2_reload_q;
    reg        timer2_overflow_flag_q;
    reg [1:0]  state_q;
    reg [3:0]  tick_q;
    reg [8:0]  shift_q;
    reg [2:0]  smp_q;
    reg        prev_rx_q;
    reg        rx_m_q;
    reg        rx_s_q;
    reg        ex_m_q;
    reg        ex_s_q;
    reg        ex_prev_q;
    wire       tick16;
    wire [15:0] t2_count;
    wire       maj;
    wire       bit_end;
    wire       load_ok;
    wire [7:0]  rx_byte;

    // Two of three majority.
    // A single noise spike inside the sampling window cannot flip a bit.
    function maj3;
        input [2:0] s;
        begin
            maj3 = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
        end
    endfunction

    // ****************************************************************
    // Baud source
    // ****************************************************************
    // The tick is one clock wide and comes from a flop, so every process
    // below sees it at the same edge. The count is tapped only for reads.
    urx9_baud_gen u_urx9_baud_gen (
        .clk        (clk),
        .sys_rst    (sys_rst),
        .mode3      (ctrl_q[`URX9_CTRL_MODE3]),
        .double_sel (ctrl_q[`URX9_CTRL_DOUBLE]),
        .t1_run     (ctrl_q[`URX9_CTRL_T1_RUN]),
        .t2_sel     (ctrl_q[`URX9_CTRL_T2_SEL]),
        .t2_run     (ctrl_q[`URX9_CTRL_T2_RUN]),
        .t1_reload  (t1_reload_q),
        .t2_reload  (t2_reload_q),
        .tick16     (tick16),
        .t2_count   (t2_count)
    );

    // Pin synchronisers, two flops each.
    // Only the second flop of each pair is read by logic, so a metastable
    // first stage never reaches a decision. The reset level is the idle
    // high of both pins, which keeps a false edge from following reset.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rx_m_q    <= 1'b1;
            rx_s_q    <= 1'b1;
            ex_m_q    <= 1'b1;
            ex_s_q    <= 1'b1;
            ex_prev_q <= 1'b1;
        end else begin
            rx_m_q    <= rx_pin;
            rx_s_q    <= rx_m_q;
            ex_m_q    <= timer2_external_pin;
            ex_s_q    <= ex_m_q;
            ex_prev_q <= ex_s_q;
        end
    end

    assign maj     = maj3(smp_q);
    // A bit time ends at the tick that finds the counter in state fifteen.
    assign bit_end = tick16 && (tick_q == `URX9_TICKS_PER_BIT);
    // Stop bit is not looked at, only the ninth data bit.
    // The done flag is taken as it stands before this edge, so a frame whose
    // final shift meets a software clear in the same cycle is still dropped.
    assign load_ok = !rx_done_flag &&
                     (!ctrl_q[`URX9_CTRL_MPF] || maj);

    // ****************************************************************
    // Byte order
    // ****************************************************************
    // The first data bit on the line is the least significant one, but it
    // travels furthest left in the shifter. Mirroring the eight data cells
    // puts it back at bit 0 of the buffer without a second register.
    genvar bit_i;
    generate
        for (bit_i = 0; bit_i < 8; bit_i = bit_i + 1) begin : g_mirror
            assign rx_byte[bit_i] = shift_q[7 - bit_i];
        end
    endgenerate

    // ****************************************************************
    // Receive sequencer
    // ****************************************************************
    // Frame walk: a falling edge seen at a tick while idle loads all ones
    // and restarts the tick counter at one, so the detecting tick counts as
    // state zero. Each tick in state fifteen closes a bit time and shifts
    // the majority value in from the right. The start bit is rejected if
    // its majority is high. Once the zero loaded by the start bit reaches
    // the leftmost cell the ninth data bit is in hand, the final shift is
    // made and the frame is loaded or dropped. One more bit time passes in
    // the tail state, covering the stop bit, before edge hunting resumes.
    // The stop level is never sampled into any result.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q       <= ST_IDLE;
            tick_q        <= 4'h0;
            shift_q       <= `URX9_RX_ONES;
            smp_q         <= 3'b111;
            prev_rx_q     <= 1'b1;
            serial_buffer <= 8'h00;
            rx_ninth_bit  <= 1'b0;
            rx_done_flag  <= 1'b0;
        end else begin
            // Software clear via the status register; a load in the same cycle wins.
            if (reg_wr && reg_addr == `URX9_ADDR_STATUS && !reg_wdata[`URX9_ST_DONE]) begin
                rx_done_flag <= 1'b0;
            end
            if (tick16) begin
                prev_rx_q <= rx_s_q;
                tick_q    <= tick_q + 4'h1;
                if (tick_q == `URX9_SAMPLE_A) smp_q[0] <= rx_s_q;
                if (tick_q == `URX9_SAMPLE_B) smp_q[1] <= rx_s_q;
                if (tick_q == `URX9_SAMPLE_C) smp_q[2] <= rx_s_q;
            end
            case (state_q)
                ST_IDLE: begin
                    if (tick16 && prev_rx_q && !rx_s_q && ctrl_q[`URX9_CTRL_RX_EN]) begin
                        shift_q <= `URX9_RX_ONES;
                        tick_q  <= 4'h1;
                        state_q <= ST_FRAME;
                    end
                end
                ST_FRAME: begin
                    if (bit_end) begin
                        if (shift_q == `URX9_RX_ONES && maj) begin
                            state_q <= ST_IDLE;
                        end else if (!shift_q[8]) begin
                            // Final shift: start bit sits at the left, maj is bit nine.
                            shift_q <= {shift_q[7:0], maj};
                            if (load_ok) begin
                                serial_buffer <= rx_byte;
                                rx_ninth_bit  <= maj;
                                rx_done_flag  <= 1'b1;
                            end
                            state_q <= ST_TAIL;
                        end else begin
                            shift_q <= {shift_q[7:0], maj};
                        end
                    end
                end
                ST_TAIL: begin
                    if (bit_end) begin
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************************************
    // Timer 2 flags and register port
    // ****************************************************************
    // The overflow bit is plain software storage here: a rollover of the
    // baud timer never sets it and nothing here raises an interrupt.
    // The external flag is set by a synchronised falling edge when enabled;
    // a software clear in the same cycle loses to that edge.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            timer2_overflow_flag_q <= 1'b0;
            timer2_external_flag   <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == `URX9_ADDR_STATUS) begin
                timer2_overflow_flag_q <= reg_wdata[`URX9_ST_T2_OVF];
                if (!reg_wdata[`URX9_ST_T2_EXT]) timer2_external_flag <= 1'b0;
            end
            if (ctrl_q[`URX9_CTRL_EXT_EN] && ex_prev_q && !ex_s_q) begin
                timer2_external_flag <= 1'b1;
            end
        end
    end

    // Register writes.
    // Map: 0 control, 1 status, 2 buffer, 3 timer 1 reload byte,
    // 4 and 5 timer 2 reload low and high, 6 and 7 timer 2 count.
    // The buffer and the count bytes are read only; a write to them, or to
    // an unused index, is dropped. The reload pair should be written with
    // the timer stopped, since a running reload may meet a half-written pair.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctrl_q      <= `URX9_CTRL_RESET;
            t1_reload_q <= 8'h00;
            t2_reload_q <= 16'h0000;
        end else if (reg_wr) begin
            case (reg_addr)
                `URX9_ADDR_CTRL:      ctrl_q            <= reg_wdata;
                `URX9_ADDR_T1_RELOAD: t1_reload_q       <= reg_wdata;
                `URX9_ADDR_T2_RLD_LO: t2_reload_q[7:0]  <= reg_wdata;
                `URX9_ADDR_T2_RLD_HI: t2_reload_q[15:8] <= reg_wdata;
                default: ;
            endcase
        end
    end

    // Register reads, data valid the cycle after the strobe.
    // The data bus returns to zero in every other cycle so a stale value
    // can never be mistaken for a fresh answer. The count bytes move every
    // second clock while timer 2 runs, so they are only meaningful once it
    // has been stopped.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            case (reg_addr)
                `URX9_ADDR_CTRL:      reg_rdata <= ctrl_q;
                `URX9_ADDR_STATUS:    reg_rdata <= {3'b000, state_q != ST_IDLE,
                                                    timer2_external_flag,
                                                    timer2_overflow_flag_q,
                                                    rx_ninth_bit, rx_done_flag};
                `URX9_ADDR_BUF:       reg_rdata <= serial_buffer;
                `URX9_ADDR_T1_RELOAD: reg_rdata <= t1_reload_q;
                `URX9_ADDR_T2_RLD_LO: reg_rdata <= t2_reload_q[7:0];
                `URX9_ADDR_T2_RLD_HI: reg_rdata <= t2_reload_q[15:8];
                `URX9_ADDR_T2_CNT_LO: reg_rdata <= t2_count[7:0];
                `URX9_ADDR_T2_CNT_HI: reg_rdata <= t2_count[15:8];
                default:              reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

endmodule

// >>> urx9_defines.vh
/*
 * Constants for the nine-bit serial receiver and its baud generation.
 * Assumes inclusion by bare name from the design files.
 */
`ifndef URX9_DEFINES_VH
`define URX9_DEFINES_VH

// ****************************************************************
// Register map (word index equals byte offset here, 8-bit data)
// ****************************************************************
`define URX9_ADDR_CTRL      4'h0
`define URX9_ADDR_STATUS    4'h1
`define URX9_ADDR_BUF       4'h2
`define URX9_ADDR_T1_RELOAD 4'h3
`define URX9_ADDR_T2_RLD_LO 4'h4
`define URX9_ADDR_T2_RLD_HI 4'h5
`define URX9_ADDR_T2_CNT_LO 4'h6
`define URX9_ADDR_T2_CNT_HI 4'h7

// Control register fields.
`define URX9_CTRL_RX_EN     0
`define URX9_CTRL_MPF       1
`define URX9_CTRL_DOUBLE    2
`define URX9_CTRL_MODE3     3
`define URX9_CTRL_T2_SEL    4
`define URX9_CTRL_T2_RUN    5
`define URX9_CTRL_EXT_EN    6
`define URX9_CTRL_T1_RUN    7
`define URX9_CTRL_RESET     8'h00

// Status register fields.
`define URX9_ST_DONE        0
`define URX9_ST_NINTH       1
`define URX9_ST_T2_OVF      2
`define URX9_ST_T2_EXT      3
`define URX9_ST_BUSY        4

// ****************************************************************
// Timing
// ****************************************************************
`define URX9_OSC_PRESCALE   4'd12
`define URX9_RX_ONES        9'h1ff
`define URX9_TICKS_PER_BIT  4'hf
`define URX9_SAMPLE_A       4'h7
`define URX9_SAMPLE_B       4'h8
`define URX9_SAMPLE_C       4'h9
`define URX9_FIXED_DIV_HALF 2'd1
`define URX9_FIXED_DIV_FULL 2'd3

`endif

// >>> urx9_baud_gen.v
/*
 * Baud source selector: fixed oscillator ratio, timer 1 8-bit auto-reload,
 * timer 2 16-bit reload at oscillator over two. Produces a sixteen-tick
 * per bit enable pulse. Assumes clk is the oscillator clock.
 */
`timescale 1ns/1ps
`include "urx9_defines.vh"

module urx9_baud_gen (
    // Clock and reset
    input  wire        clk,
    input  wire        sys_rst,
    // Configuration
    input  wire        mode3,
    input  wire        double_sel,
    input  wire        t1_run,
    input  wire        t2_sel,
    input  wire        t2_run,
    input  wire [7:0]  t1_reload,
    input  wire [15:0] t2_reload,
    // Outputs
    output reg         tick16,
    output wire [15:0] t2_count
);

    reg [3:0]  pre_q;
    reg        half_q;
    reg [7:0]  t1_cnt_q;
    reg        t1_half_q;
    reg [15:0] t2_cnt_q;
    reg [1:0]  fix_q;
    wire       fix_wrap;
    wire       t1_ovf;
    wire       t2_ovf;
    wire       src_pulse;

    assign t2_count = t2_cnt_q;
    assign t1_ovf   = (pre_q == 4'd0) && (t1_cnt_q == 8'hff) && t1_run;
    assign t2_ovf   = half_q && (t2_cnt_q == 16'hffff) && t2_run;

    // Fixed rate: doubling clear wraps every second clock (osc/32 baud),
    // doubling set wraps every fourth clock (osc/64 baud).
    assign fix_wrap = (!double_sel && fix_q == `URX9_FIXED_DIV_HALF) ||
                      (fix_q == `URX9_FIXED_DIV_FULL);

    // Timer 1 runs once per twelve oscillator clocks and auto-reloads.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            pre_q    <= 4'd0;
            half_q   <= 1'b0;
            t1_cnt_q <= 8'h00;
            t2_cnt_q <= 16'h0000;
        end else begin
            pre_q  <= (pre_q == `URX9_OSC_PRESCALE - 4'd1) ? 4'd0 : pre_q + 4'd1;
            half_q <= ~half_q;
            // A stopped timer follows its reload value, so it starts a full
            // period from the reload and never from a stale count.
            if (!t1_run) begin
                t1_cnt_q <= t1_reload;
            end else if (pre_q == 4'd0) begin
                t1_cnt_q <= t1_ovf ? t1_reload : t1_cnt_q + 8'h01;
            end
            if (!t2_run) begin
                t2_cnt_q <= t2_reload;
            end else if (half_q) begin
                t2_cnt_q <= t2_ovf ? t2_reload : t2_cnt_q + 16'h0001;
            end
        end
    end

    // Overflow halving unless doubled, then sixteen ticks per bit.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            t1_half_q <= 1'b0;
            fix_q     <= 2'd0;
        end else begin
            if (t1_ovf) begin
                t1_half_q <= ~t1_half_q;
            end
            if (fix_wrap) begin
                fix_q <= 2'd0;
            end else begin
                fix_q <= fix_q + 2'd1;
            end
        end
    end

    // Timer 2 overflow at osc/2 gives osc/(32*(65536-reload)) after the 16x split.
    assign src_pulse = !mode3 ? fix_wrap :
                       t2_sel ? t2_ovf :
                       (t1_ovf && (double_sel || t1_half_q));

    // Registered tick: sixteen per bit from the selected source.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            tick16 <= 1'b0;
        end else begin
            tick16 <= src_pulse;
        end
    end

endmodule

// >>> urx9_rx_monitor.sv
/*
 * Port checker for the nine-bit receiver.
 * Assumes it is bound to urx9_receiver and shares its clock and reset.
 */
`timescale 1ns/1ps
module urx9_rx_monitor (
    // Clock and reset
    input wire       clk,
    input wire       sys_rst,
    // Register port
    input wire [3:0] reg_addr,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata,
    // Pins and status
    input wire       rx_pin,
    input wire       timer2_external_pin,
    input wire       rx_done_flag,
    input wire       rx_ninth_bit,
    input wire [7:0] serial_buffer,
    input wire       timer2_external_flag
);
    // ****
    // Helper ages
    // ****
    reg  [11:0] low_age_q;
    reg  [9:0]  gap_q;
    reg  [3:0]  fall_age_q;
    reg         ext_q;
    reg         done_q;
    wire        clr_wr = reg_wr && (reg_addr == 4'h1) && !reg_wdata[0];

    // Saturating ages since the line was low, the last load and the last pin fall.
    always @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            low_age_q  <= 12'hfff;
            gap_q      <= 10'h3ff;
            fall_age_q <= 4'hf;
            ext_q      <= 1'b1;
            done_q     <= 1'b0;
        end else begin
            ext_q      <= timer2_external_pin;
            done_q     <= rx_done_flag;
            low_age_q  <= !rx_pin ? 12'h000 : low_age_q + {11'h000, low_age_q != 12'hfff};
            gap_q      <= (rx_done_flag && !done_q) ? 10'h000 : gap_q + {9'h000, gap_q != 10'h3ff};
            fall_age_q <= (ext_q && !timer2_external_pin) ? 4'h0 :
                          fall_age_q + {3'h0, fall_age_q != 4'hf};
        end
    end

    // ****
    // Assertions
    // ****
    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    held_frame_a: assert property (
        rx_done_flag && !clr_wr |=> rx_done_flag && $stable(serial_buffer) && $stable(rx_ninth_bit))
        else $error("held frame disturbed");
    done_clear_a: assert property (
        clr_wr && rx_done_flag |=> !rx_done_flag) else $error("done flag not cleared");
    load_cause_a: assert property (
        !$stable(serial_buffer) || !$stable(rx_ninth_bit) |-> $rose(rx_done_flag))
        else $error("buffer changed without load");
    read_buf_a: assert property (
        reg_rd && reg_addr == 4'h2 |=> reg_rdata == $past(serial_buffer))
        else $error("buffer read wrong");
    read_status_a: assert property (
        reg_rd && reg_addr == 4'h1 |=> reg_rdata[3:0] ==
        {$past(timer2_external_flag), 1'b0, $past(rx_ninth_bit), $past(rx_done_flag)})
        else $error("status read wrong");
    ext_cause_a: assert property (
        $rose(timer2_external_flag) |-> fall_age_q < 4'h8) else $error("external flag w/o fall");
    load_gap_a: assert property (
        $rose(rx_done_flag) |-> gap_q >= 10'd320) else $error("loads too close");
    start_seen_a: assert property (
        $rose(rx_done_flag) |-> low_age_q < 12'd4000) else $error("load without start bit");

    cover property ($rose(rx_done_flag));
    cover property ($rose(timer2_external_flag));
    cover property (clr_wr && rx_done_flag);
endmodule

bind urx9_receiver urx9_rx_monitor u_urx9_rx_monitor (
    .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
    .timer2_external_pin(timer2_external_pin), .rx_done_flag(rx_done_flag),
    .rx_ninth_bit(rx_ninth_bit), .serial_buffer(serial_buffer),
    .timer2_external_flag(timer2_external_flag));

// >>> urx9_tx_model.sv
/*
 * Remote transmitter model that drives the receive line.
 * Assumes its tasks are called just after a rising clock edge.
 */
`timescale 1ns/1ps
module urx9_tx_model (
    // Clock
    input wire clk,
    // Serial line
    output reg line
);
    // The line idles high until a frame starts.
    initial line = 1'b1;

    // Holds one level for n clocks.
    task hold(input logic lvl, input integer n);
        integer k;
        begin
            line <= lvl;
            for (k = 0; k < n; k = k + 1) @(posedge clk);
        end
    endtask

    // Sends start, eight data bits LSB first, the ninth bit and the stop level.
    task send(input logic [8:0] d, input integer bt, input logic stp, input logic nz);
        integer j;
        begin
            hold(1'b0, bt);
            for (j = 0; j < 9; j = j + 1) begin
                if (nz && j == 0) begin
                    hold(d[0], bt / 2);
                    hold(!d[0], bt / 16);
                    hold(d[0], bt - bt / 2 - bt / 16);
                end else
                    hold(d[j], bt);
            end
            hold(stp, bt);
        end
    endtask
endmodule

// >>> tb_urx9_receiver.sv
/*
 * Bench for the nine-bit receiver: register tasks and frames from the model.
 * Assumes the checker binds itself to the receiver.
 */
`timescale 1ns/1ps
module tb_urx9_receiver;
    // ****
    // Signals
    // ****
    reg         clk;
    reg         sys_rst;
    reg  [3:0]  reg_addr;
    reg  [7:0]  reg_wdata;
    reg         reg_wr;
    reg         reg_rd;
    reg         ext_pin;
    wire [7:0]  reg_rdata;
    wire [7:0]  serial_buffer;
    wire        rx_pin;
    wire        rx_done_flag;
    wire        rx_ninth_bit;
    wire        ext_flag;
    logic [7:0] got;
    integer     fail_count;
    integer     samples_checked;

    urx9_receiver u_urx9_receiver (
        .clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rx_pin(rx_pin),
        .timer2_external_pin(ext_pin), .rx_done_flag(rx_done_flag),
        .rx_ninth_bit(rx_ninth_bit), .serial_buffer(serial_buffer),
        .timer2_external_flag(ext_flag));
    urx9_tx_model u_urx9_tx_model (.clk(clk), .line(rx_pin));

    // The 200 MHz clock.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ****
    // Tasks
    // ****
    // Counts a comparison and reports a mismatch.
    task chk(input logic [8:0] g, input logic [8:0] e);
        begin
            samples_checked = samples_checked + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("mismatch at %0t: got %h expected %h", $time, g, e);
            end
        end
    endtask

    // One-cycle register write.
    task wr(input logic [3:0] a, input logic [7:0] d);
        begin
            reg_addr  <= a;
            reg_wdata <= d;
            reg_wr    <= 1'b1;
            @(posedge clk);
            reg_wr    <= 1'b0;
            @(posedge clk);
        end
    endtask

    // One-cycle register read; the data stand in the following cycle only.
    task rd(input logic [3:0] a, output logic [7:0] d);
        begin
            reg_addr <= a;
            reg_rd   <= 1'b1;
            @(posedge clk);
            reg_rd   <= 1'b0;
            #1 d = reg_rdata;
            @(posedge clk);
        end
    endtask

    // Compares the done flag, the ninth bit and buffer, and the buffer read back.
    task rx_chk(input logic f, input logic [8:0] v);
        logic [7:0] g;
        begin
            chk({8'h00, rx_done_flag}, {8'h00, f});
            chk({rx_ninth_bit, serial_buffer}, v);
            rd(4'h2, g);
            chk({1'b0, g}, {1'b0, v[7:0]});
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task give_verdict;
        begin
            $display("checks %0d mismatches %0d", samples_checked, fail_count);
            if (fail_count == 0 && samples_checked > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask

    // Cuts a hang short.
    initial begin
        #400000;
        fail_count = fail_count + 1;
        give_verdict;
    end

    // ****
    // Tests
    // ****
    // Main sequence; timer 2 reload fffe gives 64 clocks a bit.
    initial begin
        fail_count = 0;
        samples_checked = 0;
        sys_rst = 1'b1;
        reg_addr = 4'h0;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        ext_pin = 1'b1;
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        rx_chk(1'b0, 9'h000);
        rd(4'h0, got);
        chk({1'b0, got}, 9'h000);
        rd(4'hf, got);
        chk({1'b0, got}, 9'h000);
        wr(4'h4, 8'hfe);
        wr(4'h5, 8'hff);
        wr(4'h0, 8'h39);
        u_urx9_tx_model.send(9'h1a5, 64, 1'b1, 1'b0);
        rx_chk(1'b1, 9'h1a5);
        u_urx9_tx_model.send(9'h03c, 64, 1'b1, 1'b0);
        rx_chk(1'b1, 9'h1a5);
        wr(4'h1, 8'h00);
        u_urx9_tx_model.send(9'h05a, 64, 1'b0, 1'b1);
        u_urx9_tx_model.hold(1'b1, 64);
        rx_chk(1'b1, 9'h05a);
        wr(4'h1, 8'h00);
        u_urx9_tx_model.hold(1'b0, 16);
        u_urx9_tx_model.hold(1'b1, 640);
        rx_chk(1'b0, 9'h05a);
        rd(4'h1, got);
        chk({1'b0, got & 8'h10}, 9'h000);
        wr(4'h0, 8'h3b);
        u_urx9_tx_model.send(9'h0c3, 64, 1'b1, 1'b0);
        u_urx9_tx_model.send(9'h1c3, 64, 1'b1, 1'b0);
        rx_chk(1'b1, 9'h1c3);
        rd(4'h1, got);
        chk({1'b0, got & 8'h0f}, 9'h003);
        wr(4'h0, 8'h79);
        ext_pin <= 1'b0;
        repeat (8) @(posedge clk);
        chk({8'h00, ext_flag}, 9'h001);
        rx_chk(1'b1, 9'h1c3);
        ext_pin <= 1'b1;
        wr(4'h1, 8'h00);
        chk({8'h00, ext_flag}, 9'h000);
        wr(4'h0, 8'h01);
        rd(4'h6, got);
        chk({1'b0, got}, 9'h0fe);
        rd(4'h7, got);
        chk({1'b0, got}, 9'h0ff);
        u_urx9_tx_model.send(9'h112, 32, 1'b1, 1'b0);
        rx_chk(1'b1, 9'h112);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h05);
        u_urx9_tx_model.send(9'h0e7, 64, 1'b1, 1'b0);
        rx_chk(1'b1, 9'h0e7);
        wr(4'h1, 8'h00);
        wr(4'h3, 8'hff);
        wr(4'h0, 8'h8d);
        u_urx9_tx_model.send(9'h16b, 192, 1'b1, 1'b0);
        rx_chk(1'b1, 9'h16b);
        wr(4'h1, 8'h00);
        wr(4'h0, 8'h89);
        u_urx9_tx_model.send(9'h0f0, 384, 1'b1, 1'b0);
        rx_chk(1'b1, 9'h0f0);
        give_verdict;
    end
endmodule
